// ==== verilog/emt_pkg.sv ====
// package for the external memory strobe timing block: register map,
// field positions, reset values, sequencer states and pin bundles.
// assumes a single 100 MHz system clock shared by bus, core and pins.
package emt_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] OFS_TIMING = 8'h00; // external_bus_timing_control
   localparam logic [7:0] OFS_CONFIG = 8'h04; // external_bus_configuration
   localparam logic [7:0] OFS_PAGE = 8'h08; // external_page_register
   localparam logic [7:0] OFS_ROUTE = 8'h0C; // port group select
   localparam logic [7:0] OFS_STATUS = 8'h10; // read-only state

   // timing register fields
   localparam int SETUP_LSB = 6; // address_setup_cycles, 2 bits
   localparam int WIDTH_LSB = 2; // strobe_width_cycles, 4 bits
   localparam int HOLD_LSB = 0; // address_hold_cycles, 2 bits

   // configuration register fields
   localparam int CFG_DEMUX_BIT = 4; // bus_demux_select
   localparam int CFG_MODE_LSB = 2; // memory mode, 2 bits
   localparam int CFG_ALE_LSB = 0; // latch_strobe_width, 2 bits
   localparam logic [1:0] MODE_BANK = 2'h2; // split mode with bank select

   // status register fields
   localparam int STAT_BUSY_BIT = 0; // access in flight
   localparam int STAT_RDATA_LSB = 8; // last byte read from memory

   // reset values: setup and hold start at their longest settings
   localparam logic [7:0] TIMING_RST = 8'hFF;
   localparam logic [4:0] CONFIG_RST = 5'h00;
   localparam logic [7:0] PAGE_RST = 8'h00;
   localparam logic ROUTE_RST = 1'b0;

   // fixed overhead of an access, split before and after the strobe
   localparam logic [4:0] LEAD_CYCLES = 5'h02;
   localparam logic [4:0] TRAIL_CYCLES = 5'h02;

   // access sequencer states
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_LEAD = 7'h02,
      ST_ALE_HI = 7'h04,
      ST_ALE_LO = 7'h08,
      ST_SETUP = 7'h10,
      ST_STROBE = 7'h20,
      ST_HOLD = 7'h40
   } emt_state_e;

   // off-chip access request from the core
   typedef struct packed {
      logic write; // 1 = write, 0 = read
      logic wide; // 1 = wide_data_pointer access, 0 = 8-bit pointer access
      logic [15:0] addr; // wide_data_pointer value
      logic [7:0] ptr_lo; // pointer_reg_zero or pointer_reg_one value
      logic [7:0] wdata; // byte to write
   } emt_req_s;

   // one port group's worth of memory bus pins
   typedef struct packed {
      logic [7:0] addr_hi; // upper address byte
      logic addr_hi_oe; // high while driving addr_hi
      logic [7:0] addr_lo; // lower address byte, non-multiplexed only
      logic addr_lo_oe; // high while driving addr_lo
      logic [7:0] data_o; // data lane, or shared address/data lane
      logic data_oe; // high while driving the data lane
      logic ale; // address latch strobe, active high
      logic rd_n; // read strobe, active low
      logic wr_n; // write strobe, active low
   } emt_pins_s;

   localparam emt_pins_s PINS_IDLE = '{8'h00, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1};

endpackage : emt_pkg

// ==== verilog/emt_cnt.sv ====
// loadable down counter that times each phase of an access.
// assumes the caller loads (phase length - 1) on phase entry.
module emt_cnt (
   input wire logic clk, // system clock
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic load, // load pulse
   input wire logic [4:0] load_val, // value to load
   output logic zero // count has reached zero
);

   logic [4:0] cnt_reg; // remaining cycles of the phase

   // load wins, otherwise count down and stop at zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 5'h00;
      end else if (load) begin
         cnt_reg <= load_val;
      end else if (cnt_reg != 5'h00) begin
         cnt_reg <= 5'(cnt_reg - 5'h01);
      end
   end

   assign zero = (cnt_reg == 5'h00);

endmodule : emt_cnt

// ==== verilog/emt_top.sv ====
// external memory strobe timing: ahb-lite register slave plus the access
// sequencer that drives address, data and strobes to an asynchronous memory.
// assumes the core only issues requests that target off-chip space.
//
// Contract
// - setup cycles equal timing bits 7-6
// - strobe lasts timing bits 5-2 plus one
// - address hold cycles equal timing bits 1-0
// - demux codes 101/110/111: separate wide-pointer buses
// - codes 101/111: 8-bit nonmuxed, no bank select
// - code 110: 8-bit nonmuxed with bank select
// - codes 001/010/011: wide pointer multiplexed timing
// - codes 001/011: 8-bit muxed, no bank select
// - code 010: 8-bit muxed with bank select
// - muxed: pointer low byte before write data
// - latch strobe high, then low, 1-4 cycles
// - write data leads strobe end 1-19 cycles
// - write data held 0-3 cycles after strobe
// - bus routed to lower or upper group
// - config bit 4 clear muxed, set nonmuxed
// - access lasts setup+strobe+hold plus four, plus twice the latch width when muxed
// - latch width code 00:1, 01/10:2, 11:4
// - 8-bit pointer: bank select drives page byte, else undriven; wide pointer drives its high byte
//
// The AHB-Lite slave port and the address map are this design's own decisions.
module emt_top (
   input wire logic hclk, // system clock, 100 MHz
   input wire logic hresetn, // asynchronous reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // 1 = write
   input wire logic [2:0] hsize, // transfer size, words only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready, never stalls
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data
   input wire logic req_valid, // core offers an off-chip access
   input wire emt_pkg::emt_req_s req, // access details
   output logic req_ready, // sequencer idle, request taken
   output logic done, // one-cycle pulse at access end
   output logic [7:0] rdata, // last byte read
   output emt_pkg::emt_pins_s lower_pins, // lower port group pins
   input wire logic [7:0] lower_data_i, // lower group data lane input
   output emt_pkg::emt_pins_s upper_pins, // upper port group pins
   input wire logic [7:0] upper_data_i // upper group data lane input
);
   import emt_pkg::*;

   // every check below lives in the system clock domain and sleeps in reset
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // registers
   logic [7:0] timing_reg; // external_bus_timing_control
   logic [4:0] config_reg; // external_bus_configuration
   logic [7:0] page_reg; // external_page_register
   logic route_reg; // 1 = upper port group
   // snapshot taken when an access starts
   logic [7:0] act_timing_reg;
   logic [4:0] act_config_reg;
   logic [7:0] act_page_reg;
   logic act_route_reg;
   emt_req_s act_req_reg;
   // sequencer
   emt_state_e state_reg;
   emt_state_e state_next;
   logic cnt_load;
   logic [4:0] cnt_val;
   logic cnt_zero;
   logic done_reg;
   logic [7:0] rdata_reg;
   // bus address phase
   logic ap_valid_reg;
   logic ap_write_reg;
   logic [7:0] ap_addr_reg;
   logic [31:0] hrdata_reg;
   logic [31:0] read_mux;
   // decoded timing of the running access
   logic [4:0] setup_cyc;
   logic [4:0] width_cyc;
   logic [4:0] hold_cyc;
   logic [4:0] ale_cyc;
   logic mux_mode;
   logic bank_sel;
   logic busy;
   emt_pins_s act_pins; // pins of the group that carries the access
   logic tail_reg; // lead state is being reused as the trailing overhead
   logic tail_next; // next value of tail_reg
   logic in_acc; // phases in which the address is driven
   logic wr_phase; // phases in which write data is driven
   logic [7:0] lane_addr; // low address byte of the running access
   logic [4:0] strb_len_reg; // cycles spent in the strobe so far
   logic [5:0] acc_len_reg; // cycles since the access was taken
   logic [5:0] acc_exp; // length the running access must have

   // latch strobe width code to cycles
   function automatic logic [4:0] ale_len(input logic [1:0] code);
      case (code)
         2'h0: ale_len = 5'h01;
         2'h1, 2'h2: ale_len = 5'h02;
         default: ale_len = 5'h04;
      endcase
   endfunction : ale_len

   // ---------------- ahb-lite slave ----------------
   assign hreadyout = 1'b1; // zero wait states
   assign hresp = 1'b0; // okay
   assign hrdata = hrdata_reg;

   // register read map, unmapped reads as zero
   always_comb begin
      read_mux = 32'h0000_0000;
      case (haddr[7:0])
         OFS_TIMING: read_mux = {24'h000000, timing_reg};
         OFS_CONFIG: read_mux = {27'h0000000, config_reg};
         OFS_PAGE: read_mux = {24'h000000, page_reg};
         OFS_ROUTE: read_mux = {31'h00000000, route_reg};
         OFS_STATUS: begin
            read_mux[STAT_BUSY_BIT] = busy;
            read_mux[STAT_RDATA_LSB +: 8] = rdata_reg;
         end
         default: read_mux = 32'h0000_0000;
      endcase
   end

   // capture the address phase; read data is loaded here for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_reg <= 1'b0;
         ap_write_reg <= 1'b0;
         ap_addr_reg <= 8'h00;
         hrdata_reg <= 32'h0000_0000;
      end else if (hready) begin
         ap_valid_reg <= hsel && htrans[1] && (hsize == 3'h2);
         ap_write_reg <= hwrite;
         ap_addr_reg <= haddr[7:0];
         if (hsel && htrans[1] && !hwrite) begin
            hrdata_reg <= read_mux;
         end
      end
   end

   // register writes in the data phase, unmapped writes ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timing_reg <= TIMING_RST;
         config_reg <= CONFIG_RST;
         page_reg <= PAGE_RST;
         route_reg <= ROUTE_RST;
      end else if (ap_valid_reg && ap_write_reg) begin
         case (ap_addr_reg)
            OFS_TIMING: timing_reg <= hwdata[7:0];
            OFS_CONFIG: config_reg <= hwdata[4:0];
            OFS_PAGE: page_reg <= hwdata[7:0];
            OFS_ROUTE: route_reg <= hwdata[0];
            default: ; // read-only or unmapped
         endcase
      end
   end

   // ---------------- access sequencer ----------------
   assign busy = (state_reg != ST_IDLE);
   assign req_ready = !busy;
   assign done = done_reg;
   assign rdata = rdata_reg;

   assign setup_cyc = {3'h0, act_timing_reg[SETUP_LSB +: 2]};
   assign width_cyc = 5'({1'b0, act_timing_reg[WIDTH_LSB +: 4]} + 5'h01);
   assign hold_cyc = {3'h0, act_timing_reg[HOLD_LSB +: 2]};
   assign ale_cyc = ale_len(act_config_reg[CFG_ALE_LSB +: 2]);
   assign mux_mode = !act_config_reg[CFG_DEMUX_BIT];
   assign bank_sel = (act_config_reg[CFG_MODE_LSB +: 2] == MODE_BANK);

   // snapshot settings and request so mid-access writes cannot tear timing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_timing_reg <= TIMING_RST;
         act_config_reg <= CONFIG_RST;
         act_page_reg <= PAGE_RST;
         act_route_reg <= ROUTE_RST;
         act_req_reg <= '0;
      end else if (req_valid && !busy) begin
         act_timing_reg <= timing_reg;
         act_config_reg <= config_reg;
         act_page_reg <= page_reg;
         act_route_reg <= route_reg;
         act_req_reg <= req;
      end
   end

   // phase order: lead, latch high/low (muxed), setup, strobe, hold, trail;
   // the trail reuses the lead state with tail_reg set
   always_comb begin
      state_next = state_reg;
      tail_next = tail_reg;
      cnt_load = 1'b0;
      cnt_val = 5'h00;
      case (state_reg)
         ST_IDLE: begin
            if (req_valid) begin
               state_next = ST_LEAD;
               tail_next = 1'b0;
               cnt_load = 1'b1;
               cnt_val = 5'(LEAD_CYCLES - 5'h01);
            end
         end
         ST_LEAD, ST_ALE_LO: begin
            if (cnt_zero) begin
               cnt_load = 1'b1;
               if (state_reg == ST_LEAD && tail_reg) begin
                  state_next = ST_IDLE; // trailing overhead over
                  tail_next = 1'b0;
                  cnt_load = 1'b0;
               end else if (state_reg == ST_LEAD && mux_mode) begin
                  state_next = ST_ALE_HI;
                  cnt_val = 5'(ale_cyc - 5'h01);
               end else if (setup_cyc != 5'h00) begin
                  state_next = ST_SETUP;
                  cnt_val = 5'(setup_cyc - 5'h01);
               end else begin
                  state_next = ST_STROBE;
                  cnt_val = 5'(width_cyc - 5'h01);
               end
            end
         end
         ST_ALE_HI: begin
            if (cnt_zero) begin
               state_next = ST_ALE_LO;
               cnt_load = 1'b1;
               cnt_val = 5'(ale_cyc - 5'h01);
            end
         end
         ST_SETUP: begin
            if (cnt_zero) begin
               state_next = ST_STROBE;
               cnt_load = 1'b1;
               cnt_val = 5'(width_cyc - 5'h01);
            end
         end
         ST_STROBE: begin
            if (cnt_zero) begin
               cnt_load = 1'b1;
               if (hold_cyc != 5'h00) begin
                  state_next = ST_HOLD;
                  cnt_val = 5'(hold_cyc - 5'h01);
               end else begin
                  state_next = ST_LEAD; // zero hold: straight to the trail
                  tail_next = 1'b1;
                  cnt_val = 5'(TRAIL_CYCLES - 5'h01);
               end
            end
         end
         ST_HOLD: begin
            if (cnt_zero) begin
               state_next = ST_LEAD; // trail follows the hold
               tail_next = 1'b1;
               cnt_load = 1'b1;
               cnt_val = 5'(TRAIL_CYCLES - 5'h01);
            end
         end
         default: begin
            state_next = ST_IDLE;
            tail_next = 1'b0;
         end
      endcase
   end

   // phase timer shared by all phases
   emt_cnt u_cnt (
      .clk(hclk),
      .rst_n(hresetn),
      .load(cnt_load),
      .load_val(cnt_val),
      .zero(cnt_zero)
   );

   // sequencer state and trail flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
         tail_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tail_reg <= tail_next;
      end
   end

   // done pulse at the end of the trail
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= (state_reg == ST_LEAD) && tail_reg && cnt_zero;
      end
   end

   // read byte taken in the last strobe cycle, while memory still drives it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= 8'h00;
      end else if (state_reg == ST_STROBE && cnt_zero && !act_req_reg.write) begin
         rdata_reg <= act_route_reg ? upper_data_i : lower_data_i;
      end
   end

   // low address byte: wide pointer or 8-bit pointer register
   assign lane_addr = act_req_reg.wide ? act_req_reg.addr[7:0] : act_req_reg.ptr_lo;

   // pin decode from the registered state and snapshot
   always_comb begin
      in_acc = (state_reg == ST_ALE_HI) || (state_reg == ST_ALE_LO) || (state_reg == ST_SETUP) ||
         (state_reg == ST_STROBE) || (state_reg == ST_HOLD);
      wr_phase = act_req_reg.write && ((state_reg == ST_SETUP) || (state_reg == ST_STROBE) ||
         (state_reg == ST_HOLD));
      act_pins = PINS_IDLE;
      // upper byte: pointer high byte, or page byte in bank select mode
      act_pins.addr_hi = act_req_reg.wide ? act_req_reg.addr[15:8] : act_page_reg;
      act_pins.addr_hi_oe = in_acc && (act_req_reg.wide || bank_sel);
      act_pins.addr_lo = lane_addr;
      act_pins.addr_lo_oe = in_acc && !mux_mode;
      if (mux_mode && ((state_reg == ST_ALE_HI) || (state_reg == ST_ALE_LO))) begin
         // shared lane carries the address around the latch strobe
         act_pins.data_o = lane_addr;
         act_pins.data_oe = 1'b1;
      end else begin
         // then write data, or released for the memory to drive
         act_pins.data_o = act_req_reg.wdata;
         act_pins.data_oe = wr_phase;
      end
      act_pins.ale = mux_mode && (state_reg == ST_ALE_HI);
      act_pins.rd_n = !((state_reg == ST_STROBE) && !act_req_reg.write);
      act_pins.wr_n = !((state_reg == ST_STROBE) && act_req_reg.write);
   end

   // only the selected port group carries the bus, the other stays idle
   assign lower_pins = act_route_reg ? PINS_IDLE : act_pins;
   assign upper_pins = act_route_reg ? act_pins : PINS_IDLE;

   // helper counters for the timing checks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strb_len_reg <= 5'h00;
         acc_len_reg <= 6'h00;
      end else begin
         strb_len_reg <= (state_reg == ST_STROBE) ? 5'(strb_len_reg + 5'h01) : 5'h00;
         acc_len_reg <= busy ? 6'(acc_len_reg + 6'h01) : 6'h00;
      end
   end

   // expected length, minus one because the counter starts at zero
   assign acc_exp = {1'b0, setup_cyc} + {1'b0, width_cyc} + {1'b0, hold_cyc} +
      (mux_mode ? {ale_cyc, 1'b0} : 6'h00) + {1'b0, LEAD_CYCLES} + {1'b0, TRAIL_CYCLES} - 6'h01;

   // latch strobe steps: last high cycle, then low with address still on
   sequence s_ale_hi_last;
      state_reg == ST_ALE_HI && cnt_zero && act_pins.ale;
   endsequence
   sequence s_ale_lo_first;
      state_reg == ST_ALE_LO && !act_pins.ale && act_pins.data_oe;
   endsequence

   chk_strobe_exclusive: assert property (act_pins.rd_n || act_pins.wr_n)
      else $error("read and write strobes low together");
   chk_strobe_width: assert property ((state_reg == ST_STROBE && cnt_zero) |->
      (strb_len_reg == 5'(width_cyc - 5'h01)))
      else $error("strobe width differs from its setting");
   chk_ale_order: assert property (s_ale_hi_last |=> s_ale_lo_first)
      else $error("latch strobe did not fall after its high time");
   chk_lane_address: assert property ((mux_mode && state_reg == ST_ALE_HI) |->
      (act_pins.data_oe && act_pins.data_o == lane_addr))
      else $error("shared lane lacks the low address while latching");
   chk_upper_byte: assert property ((in_acc && !act_req_reg.wide && !bank_sel) |->
      !act_pins.addr_hi_oe)
      else $error("upper address byte driven without bank select");
   chk_access_length: assert property ((state_reg == ST_LEAD && tail_reg && cnt_zero) |->
      (acc_len_reg == acc_exp))
      else $error("access length differs from its settings");
   chk_wdata_hold: assert property ((state_reg == ST_STROBE && cnt_zero && act_req_reg.write) |=>
      (act_pins.data_oe == (hold_cyc != 5'h00)))
      else $error("write data hold differs from its setting");
endmodule : emt_top

// ==== test/emt_mem.sv ====
// behavioural asynchronous byte memory standing behind one port group.
// assumes an external address latch that is transparent while ale is high.
module emt_mem
   import emt_pkg::*;
(
   input wire emt_pkg::emt_pins_s pins, // pins from the device
   output logic [7:0] data_i // data lane back to the device
);
   logic [7:0] mem [0:65535]; // storage array
   logic [7:0] lat = 8'h00; // address latch on the shared lane
   logic [15:0] a; // effective address
   // latch follows the shared lane while ale is high
   always @(pins.ale or pins.data_o) begin
      if (pins.ale) begin
         lat = pins.data_o;
      end
   end
   // undriven upper byte reads as zero, muxed low byte comes from the latch
   assign a = {pins.addr_hi_oe ? pins.addr_hi : 8'h00, pins.addr_lo_oe ? pins.addr_lo : lat};
   // byte follows the lane while the write strobe is low; the address and
   // the strobe change together at the strobe end, so no edge race
   always @(pins.wr_n or a or pins.data_o) begin
      if (!pins.wr_n) begin
         mem[a] = pins.data_o;
      end
   end
   // read data only while the read strobe is low, garbage otherwise
   assign data_i = !pins.rd_n ? mem[a] : ~mem[a];
endmodule : emt_mem

// ==== test/tb_top.sv ====
// self-checking bench: ahb-lite register access, core requests and
// pin-level timing counts. assumes one memory model on each port group.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import emt_pkg::*;
   logic hclk = 1'h0; // system clock
   logic hresetn = 1'h0; // reset, active low
   logic hsel = 1'h0; // slave select
   logic hwrite = 1'h0; // write flag
   logic req_valid = 1'h0; // core request valid
   logic route = 1'h0; // group that should carry the bus
   logic [31:0] haddr = 32'h0; // bus address
   logic [31:0] hwdata = 32'h0; // bus write data
   logic [1:0] htrans = 2'h0; // transfer type
   logic [2:0] hsize = 3'h2; // word transfers only
   emt_req_s req = '0; // request details
   logic hreadyout, hresp, req_ready, done, hi_oe; // design outputs and monitor flag
   logic [31:0] hrdata; // bus read data
   logic [7:0] rdata, lo_d, up_d, hi; // returned bytes and seen upper byte
   emt_pins_s lower_pins, upper_pins, p, q; // pin groups, active and idle
   int stb_n, ale_n, n_fail, checks_done; // counters
   localparam logic [2:0] CODES [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7}; // every mode code
   localparam logic [7:0] TIMS [6] = '{8'h00, 8'h3D, 8'hE6, 8'h7F, 8'h1B, 8'hC4}; // timing settings
   localparam int ALEW [4] = '{1, 2, 2, 4}; // latch strobe width by code
   emt_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .done(done), .rdata(rdata), .lower_pins(lower_pins), .lower_data_i(lo_d),
      .upper_pins(upper_pins), .upper_data_i(up_d));
   emt_mem mem_lo (.pins(lower_pins), .data_i(lo_d));
   emt_mem mem_up (.pins(upper_pins), .data_i(up_d));
   assign p = route ? upper_pins : lower_pins;
   assign q = route ? lower_pins : upper_pins;
   // clock generator, 10 ns period
   always #5 hclk = ~hclk;
   // pin monitor: counts strobe and latch cycles, watches the idle group
   always @(posedge hclk) begin
      if (hresetn) begin
         cmp(p.rd_n | p.wr_n, 32'h1);
         cmp(q.rd_n & q.wr_n, 32'h1);
         if (!p.rd_n || !p.wr_n) begin
            stb_n <= stb_n + 1;
            hi_oe <= p.addr_hi_oe;
            hi <= p.addr_hi;
         end
         if (p.ale) begin
            ale_n <= ale_n + 1;
         end
      end
   end
   // compares one value and counts it
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   // one clock edge of a bounded wait
   task automatic tick(inout int k);
      @(posedge hclk);
      k++;
      if (k > 200) begin
         n_fail++;
         give_verdict();
      end
   endtask : tick
   // single ahb-lite word transfer
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      k = 0;
      do tick(k); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= d;
      k = 0;
      do tick(k); while (hreadyout !== 1'h1);
      r = hrdata;
   endtask : ahb
   // one off-chip access offered by the core, waits for its end
   task automatic access(input logic wr, input logic wide, input logic [15:0] a, input logic [7:0] d,
      output int cyc);
      int k;
      @(posedge hclk);
      req_valid <= 1'h1;
      req <= '{wr, wide, a, a[7:0], d};
      stb_n = 0;
      ale_n = 0;
      k = 0;
      do tick(k); while (req_ready !== 1'h1);
      req_valid <= 1'h0;
      k = 0;
      do tick(k); while (done !== 1'h1);
      cyc = k;
   endtask : access
   // prints the counts and the verdict, then stops
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   // hang guard
   initial begin
      #500us;
      n_fail++;
      give_verdict();
   end
   // main sequence
   initial begin
      logic [31:0] r;
      logic [15:0] a;
      logic [7:0] d;
      int n;
      n_fail = 0;
      checks_done = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'h1;
      ahb(1'h0, OFS_TIMING, 32'h0, r);
      cmp(r[7:0], TIMING_RST);
      ahb(1'h0, OFS_CONFIG, 32'h0, r);
      cmp(r[4:0], CONFIG_RST);
      ahb(1'h1, OFS_PAGE, 32'h5A, r);
      $display("reset values done");
      for (int i = 0; i < 6; i++) begin
         ahb(1'h1, OFS_CONFIG, {27'h0, CODES[i], 2'(i)}, r);
         ahb(1'h1, OFS_TIMING, {24'h0, TIMS[i]}, r);
         ahb(1'h1, OFS_ROUTE, {31'h0, i[0]}, r);
         route = i[0];
         ahb(1'h0, OFS_TIMING, 32'h0, r);
         cmp(r[7:0], TIMS[i]);
         for (int w = 0; w < 2; w++) begin
            a = {8'h21, 8'(8'h40 + i * 2 + w)};
            d = 8'hC3 ^ a[7:0];
            access(1'h1, w[0], a, d, n);
            access(1'h0, w[0], a, 8'h00, n);
            // overhead 4, width code plus 1, and 1 more for the done pulse
            cmp(n, TIMS[i][7:6] + TIMS[i][5:2] + TIMS[i][1:0] + 6 + (CODES[i][2] ? 0 : 2 * ALEW[i % 4]));
            cmp(stb_n, TIMS[i][5:2] + 32'h1);
            cmp(ale_n, CODES[i][2] ? 0 : ALEW[i % 4]);
            cmp(rdata, d);
            cmp(hi_oe, w[0] | (CODES[i][1:0] == MODE_BANK));
            if (hi_oe === 1'h1) begin
               cmp(hi, w[0] ? a[15:8] : 8'h5A);
            end
         end
         $display("mode %h done", CODES[i]);
      end
      ahb(1'h1, 8'h20, 32'h55, r);
      ahb(1'h0, OFS_TIMING, 32'h0, r);
      cmp(r[7:0], TIMS[5]);
      ahb(1'h0, OFS_STATUS, 32'h0, r);
      cmp(r[15:0], {d, 8'h00});
      ahb(1'h0, OFS_ROUTE, 32'h0, r);
      cmp(r[0], 1'h1);
      $display("unmapped write done");
      give_verdict();
   end
endmodule : tb_top
